// ---- design/lfi_pkg.sv ----
package lfi_pkg;

  localparam int TEMP_W = 12;
  localparam logic [11:0] TEMP_LOW_RST = 12'h0000;
  localparam logic [11:0] TEMP_HIGH_RST = 12'h0FFF;

  // Soft-start and stop ramp times, in microseconds.
  localparam int RAMP_UP_US = 600;
  localparam int RAMP_DOWN_US = 800;
  localparam int CLK_MHZ = 20;
  localparam int RAMP_UP_CYC = RAMP_UP_US * CLK_MHZ;
  localparam int RAMP_DOWN_CYC = RAMP_DOWN_US * CLK_MHZ;

  typedef struct packed {
    logic cooler_overcurrent;
    logic cooler_short;
    logic cooler_overheat;
  } lfi_cooler_sense_t;

  typedef struct packed {
    logic cooler_fault_flag;
    logic emitter_overcurrent;
    logic shunt_on;
    logic red_led;
    logic yellow_led;
    logic interlock_repeat;
    logic shunt_repeat;
  } lfi_status_t;

  typedef enum logic [1:0] {
    LFI_IDLE,
    LFI_RAMP,
    LFI_RUN,
    LFI_STOP
  } lfi_drv_state_t;

endpackage

// ---- design/lfi_run_edge.sv ----
`timescale 1ns/1ns
// Arms a run request only after it has been seen low since reset.
module lfi_run_edge (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_req,
  input wire logic switch_req,
  output logic run
);

  logic armed;
  logic next_armed;
  logic req;

  always_comb begin
    req = pin_req | switch_req;
    next_armed = armed;
    if (!req) begin
      next_armed = 1'b1;
    end
    run = armed & req;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end

endmodule

// ---- design/lfi_temp_window.sv ----
`timescale 1ns/1ns
// Keeps the temperature limits and compares the thermistor reading.
module lfi_temp_window #(
  parameter int W = lfi_pkg::TEMP_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] temp_sample,
  input wire logic temp_sample_valid,
  input wire logic limits_wr,
  input wire logic [W-1:0] limit_low_in,
  input wire logic [W-1:0] limit_high_in,
  output logic [W-1:0] temp_value,
  output logic [W-1:0] limit_low,
  output logic [W-1:0] limit_high,
  output logic in_range
);

  logic [W-1:0] next_temp_value;
  logic [W-1:0] next_limit_low;
  logic [W-1:0] next_limit_high;
  logic next_in_range;

  always_comb begin
    next_temp_value = temp_value;
    next_limit_low = limit_low;
    next_limit_high = limit_high;
    if (temp_sample_valid) begin
      next_temp_value = temp_sample;
    end
    if (limits_wr) begin
      next_limit_low = limit_low_in;
      next_limit_high = limit_high_in;
    end
    next_in_range = (next_temp_value >= next_limit_low) &&
                    (next_temp_value <= next_limit_high);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_value <= '0;
      limit_low <= W'(lfi_pkg::TEMP_LOW_RST);
      limit_high <= W'(lfi_pkg::TEMP_HIGH_RST);
      in_range <= 1'b0;
    end else begin
      temp_value <= next_temp_value;
      limit_low <= next_limit_low;
      limit_high <= next_limit_high;
      in_range <= next_in_range;
    end
  end

endmodule

// ---- design/lfi_interlock.sv ----
`timescale 1ns/1ns
// Functional notes
// - Cooler run request high stabilises temperature; low stops stabilisation.
// - Emitter run request high starts soft-start ramp; low stops emitter driver.
// - Both run-request inputs pulled low; undriven input means stop.
// - Cooler fault output high on overcurrent, short or overheat; low otherwise. The code keeps the flag latched high until reset.
// - Cooler fault stops emitter and stays latched until device restart.
// - Emitter overcurrent stops driver, shunts output, lights red indicator.
// - Overcurrent output high exactly while output terminals are shunted.
// - After overcurrent trip, restart refused until the driver is restarted.
// - Interlock pulled up; open locks device, low permits operation.
// - Digital connector repeats interlock and shunt status lines.
// - On-board switches also provide cooler and emitter run requests.
// - External thermistor temperature is measured and readable digitally.
// - Temperature outside programmed limits blocks driver; back inside resumes.
// - Temperature limits are kept stored and enforced in all control modes.
// - Interlock honoured at power-up; a command may select ignoring it.
// - Request already high at power-up does not start; fresh rise needed.
module lfi_interlock #(
  parameter int TEMP_W = lfi_pkg::TEMP_W,
  parameter int RAMP_UP_CYC = lfi_pkg::RAMP_UP_CYC,
  parameter int RAMP_DOWN_CYC = lfi_pkg::RAMP_DOWN_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cooler_run_request,
  input wire logic emitter_run_request,
  input wire logic cooler_switch,
  input wire logic emitter_switch,
  input wire logic interlock_n,
  input wire logic interlock_ignore,
  input wire lfi_pkg::lfi_cooler_sense_t cooler_sense,
  input wire logic emitter_overcurrent_sense,
  input wire logic driver_restart,
  input wire logic [TEMP_W-1:0] temp_sample,
  input wire logic temp_sample_valid,
  input wire logic limits_wr,
  input wire logic [TEMP_W-1:0] limit_low_in,
  input wire logic [TEMP_W-1:0] limit_high_in,
  output logic cooler_active,
  output logic emitter_on,
  output logic emitter_ramp_up,
  output logic emitter_ramp_down,
  output lfi_pkg::lfi_status_t status,
  output logic [TEMP_W-1:0] external_thermistor_guard,
  output logic [TEMP_W-1:0] limit_low,
  output logic [TEMP_W-1:0] limit_high
);

  localparam int CW = $clog2(RAMP_DOWN_CYC > RAMP_UP_CYC ? RAMP_DOWN_CYC + 1 : RAMP_UP_CYC + 1);

  logic cooler_run;
  logic emitter_run;
  logic in_range;
  logic [TEMP_W-1:0] temp_value;
  logic [TEMP_W-1:0] low_q;
  logic [TEMP_W-1:0] high_q;
  logic cooler_fault;
  logic next_cooler_fault;
  logic overcurrent;
  logic next_overcurrent;
  logic permit;
  logic allow;
  lfi_pkg::lfi_drv_state_t state;
  lfi_pkg::lfi_drv_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  lfi_pkg::lfi_status_t next_status;
  logic next_cooler_active;
  logic next_emitter_on;
  logic next_ramp_up;
  logic next_ramp_down;

  // Pull-downs make an open input read low, which both sources treat as stop.
  lfi_run_edge u_cooler_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_req(cooler_run_request),
    .switch_req(cooler_switch),
    .run(cooler_run)
  );

  lfi_run_edge u_emitter_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_req(emitter_run_request),
    .switch_req(emitter_switch),
    .run(emitter_run)
  );

  lfi_temp_window #(
    .W(TEMP_W)
  ) u_window (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .temp_sample(temp_sample),
    .temp_sample_valid(temp_sample_valid),
    .limits_wr(limits_wr),
    .limit_low_in(limit_low_in),
    .limit_high_in(limit_high_in),
    .temp_value(temp_value),
    .limit_low(low_q),
    .limit_high(high_q),
    .in_range(in_range)
  );

  always_comb begin
    next_cooler_fault = cooler_fault | (|cooler_sense);
    next_overcurrent = overcurrent;
    if (driver_restart) begin
      next_overcurrent = 1'b0;
    end
    if (emitter_overcurrent_sense) begin
      next_overcurrent = 1'b1;
    end
    permit = !interlock_n || interlock_ignore;
    allow = emitter_run && permit && !cooler_fault && !overcurrent && in_range;
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      lfi_pkg::LFI_IDLE: begin
        if (allow) begin
          next_state = lfi_pkg::LFI_RAMP;
          next_cnt = CW'(RAMP_UP_CYC - 1);
        end
      end
      lfi_pkg::LFI_RAMP: begin
        if (!allow) begin
          next_state = lfi_pkg::LFI_STOP;
          next_cnt = CW'(RAMP_DOWN_CYC - 1);
        end else if (cnt == '0) begin
          next_state = lfi_pkg::LFI_RUN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      lfi_pkg::LFI_RUN: begin
        if (!allow) begin
          next_state = lfi_pkg::LFI_STOP;
          next_cnt = CW'(RAMP_DOWN_CYC - 1);
        end
      end
      lfi_pkg::LFI_STOP: begin
        if (cnt == '0 || overcurrent || cooler_fault) begin
          next_state = lfi_pkg::LFI_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    endcase
    next_emitter_on = (next_state == lfi_pkg::LFI_RAMP) || (next_state == lfi_pkg::LFI_RUN);
    next_ramp_up = next_state == lfi_pkg::LFI_RAMP;
    next_ramp_down = next_state == lfi_pkg::LFI_STOP;
    next_cooler_active = cooler_run && permit && !next_cooler_fault;
    next_status.cooler_fault_flag = next_cooler_fault;
    next_status.emitter_overcurrent = next_overcurrent;
    next_status.shunt_on = next_overcurrent;
    next_status.red_led = next_overcurrent;
    next_status.yellow_led = !permit;
    next_status.interlock_repeat = interlock_n;
    next_status.shunt_repeat = next_overcurrent;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cooler_fault <= 1'b0;
      overcurrent <= 1'b0;
      state <= lfi_pkg::LFI_IDLE;
      cnt <= '0;
      cooler_active <= 1'b0;
      emitter_on <= 1'b0;
      emitter_ramp_up <= 1'b0;
      emitter_ramp_down <= 1'b0;
      status <= '0;
      external_thermistor_guard <= '0;
      limit_low <= '0;
      limit_high <= '0;
    end else begin
      cooler_fault <= next_cooler_fault;
      overcurrent <= next_overcurrent;
      state <= next_state;
      cnt <= next_cnt;
      cooler_active <= next_cooler_active;
      emitter_on <= next_emitter_on;
      emitter_ramp_up <= next_ramp_up;
      emitter_ramp_down <= next_ramp_down;
      status <= next_status;
      external_thermistor_guard <= temp_value;
      limit_low <= low_q;
      limit_high <= high_q;
    end
  end

endmodule

// ---- verif/lfi_interlock_assertions.sv ----
`timescale 1ns/1ns
module lfi_interlock_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cooler_run_request,
  input wire logic cooler_switch,
  input wire logic interlock_n,
  input wire logic interlock_ignore,
  input wire lfi_pkg::lfi_cooler_sense_t cooler_sense,
  input wire logic emitter_overcurrent_sense,
  input wire logic [lfi_pkg::TEMP_W-1:0] temp_sample,
  input wire logic temp_sample_valid,
  input wire logic cooler_active,
  input wire logic emitter_on,
  input wire logic emitter_ramp_up,
  input wire lfi_pkg::lfi_status_t status,
  input wire logic [lfi_pkg::TEMP_W-1:0] external_thermistor_guard
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence start_s;
    $rose(emitter_on);
  endsequence
  sequence trip_s;
    status.emitter_overcurrent || status.cooler_fault_flag;
  endsequence
  fault_set_a: assert property (|cooler_sense |=> status.cooler_fault_flag)
    else $error("cooler fault not set");
  fault_hold_a: assert property (status.cooler_fault_flag |=> status.cooler_fault_flag)
    else $error("cooler fault dropped");
  oc_trip_a: assert property (emitter_overcurrent_sense |=> status.emitter_overcurrent)
    else $error("overcurrent not latched");
  shunt_match_a: assert property (status.shunt_on == status.emitter_overcurrent
    && status.red_led == status.emitter_overcurrent)
    else $error("shunt and overcurrent differ");
  shunt_copy_a: assert property (status.shunt_repeat == status.shunt_on)
    else $error("shunt repeat differs");
  trip_off_a: assert property (trip_s |=> !emitter_on)
    else $error("emitter runs after fault");
  ramp_first_a: assert property (start_s |-> emitter_ramp_up)
    else $error("start without ramp");
  lock_show_a: assert property (interlock_n && !interlock_ignore |=> status.yellow_led)
    else $error("lock not shown");
  cool_stop_a: assert property (!cooler_run_request && !cooler_switch |=> !cooler_active)
    else $error("cooler runs unrequested");
  temp_read_a: assert property (temp_sample_valid |-> ##2
    external_thermistor_guard == $past(temp_sample, 2))
    else $error("temperature reading wrong");
endmodule
bind lfi_interlock lfi_interlock_chk chk_u (.core_clk, .rst_n, .cooler_run_request,
  .cooler_switch, .interlock_n, .interlock_ignore, .cooler_sense,
  .emitter_overcurrent_sense, .temp_sample, .temp_sample_valid, .cooler_active,
  .emitter_on, .emitter_ramp_up, .status, .external_thermistor_guard);

// ---- verif/lfi_ctrl_model.sv ----
`timescale 1ns/1ns
// Outside controller lines; an undriven line falls to its pull level.
module lfi_ctrl_model (
  input wire logic [2:0] drive_en,
  input wire logic [2:0] drive_val,
  output logic cooler_pin,
  output logic emitter_pin,
  output logic interlock_pin
);
  assign cooler_pin = drive_en[0] ? drive_val[0] : 1'h0;
  assign emitter_pin = drive_en[1] ? drive_val[1] : 1'h0;
  assign interlock_pin = drive_en[2] ? drive_val[2] : 1'h1;
endmodule

// ---- verif/lfi_interlock_tb_top.sv ----
`timescale 1ns/1ns
module lfi_interlock_tb_top;
  logic core_clk = 0, rst_n = 0, csw = 0, esw = 0, ign = 0, drst = 0, tv = 0, lw = 0, oc = 0;
  logic [2:0] den = 3'h6, dval = 3'h2;
  lfi_pkg::lfi_cooler_sense_t cs = '0;
  logic [11:0] ts = '0, lo = '0, hi = '0, guard, llo, lhi;
  logic cpin, epin, ipin, cact, eon, rup, rdn;
  lfi_pkg::lfi_status_t st;
  int failures = 0, num_checks = 0;
  always #25 core_clk = ~core_clk;
  lfi_ctrl_model ctl_u (.drive_en(den), .drive_val(dval), .cooler_pin(cpin),
    .emitter_pin(epin), .interlock_pin(ipin));
  lfi_interlock #(.RAMP_UP_CYC(4), .RAMP_DOWN_CYC(6)) dut_u (.core_clk, .rst_n,
    .cooler_run_request(cpin), .emitter_run_request(epin), .cooler_switch(csw),
    .emitter_switch(esw), .interlock_n(ipin), .interlock_ignore(ign), .cooler_sense(cs),
    .emitter_overcurrent_sense(oc), .driver_restart(drst), .temp_sample(ts),
    .temp_sample_valid(tv), .limits_wr(lw), .limit_low_in(lo), .limit_high_in(hi),
    .cooler_active(cact), .emitter_on(eon), .emitter_ramp_up(rup), .emitter_ramp_down(rdn),
    .status(st), .external_thermistor_guard(guard), .limit_low(llo), .limit_high(lhi));
  // Returns on a rising edge; reads then see the values settled before that edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'h0;
    cyc(8);
    rst_n <= 1'h1;
    cyc(2);
  endtask
  task automatic set_em(input logic v);
    @(posedge core_clk);
    dval[1] <= v;
  endtask
  task automatic t_start;
    do_reset;
    cyc(5);
    chk(eon, 0);
    set_em(0);
    cyc(2);
    set_em(1);
    cyc(3);
    chk({eon, rup}, 2'h3);
    cyc(5);
    chk({eon, rup}, 2'h2);
    set_em(0);
    cyc(3);
    chk({eon, rdn}, 2'h1);
    cyc(8);
    chk(rdn, 0);
  endtask
  task automatic t_lock;
    set_em(1);
    cyc(12);
    den[2] <= 1'h0;
    cyc(3);
    chk({st.yellow_led, st.interlock_repeat, eon}, 3'h6);
    ign <= 1'h1;
    cyc(6);
    chk(eon, 1'h1);
    den[2] <= 1'h1;
    ign <= 1'h0;
  endtask
  task automatic t_temp;
    lw <= 1;
    lo <= 12'h0100;
    hi <= 12'h0200;
    cyc(1);
    lw <= 0;
    cyc(3);
    chk(llo, 12'h0100);
    chk(lhi, 12'h0200);
    ts <= 12'h0300;
    tv <= 1;
    cyc(1);
    tv <= 0;
    cyc(4);
    chk(eon, 0);
    chk(guard, 12'h0300);
    ts <= 12'h0200;
    tv <= 1;
    cyc(1);
    tv <= 0;
    cyc(5);
    chk(eon, 1);
  endtask
  task automatic t_oc;
    @(posedge core_clk);
    oc <= 1;
    @(posedge core_clk);
    oc <= 0;
    cyc(2);
    chk({st.emitter_overcurrent, st.shunt_on, st.red_led, st.shunt_repeat, eon}, 5'h1e);
    set_em(0);
    cyc(2);
    set_em(1);
    cyc(4);
    chk(eon, 0);
    drst <= 1;
    cyc(1);
    drst <= 0;
    cyc(2);
    chk({st.emitter_overcurrent, st.shunt_on}, 2'h0);
  endtask
  task automatic t_cool;
    for (int i = 0; i < 3; i++) begin
      set_em(0);
      do_reset;
      csw <= 1;
      dval[1] <= 1;
      cyc(4);
      chk({cact, eon, st.cooler_fault_flag}, 3'h6);
      csw <= 1'h0;
      cyc(2);
      chk(cact, 1'h0);
      csw <= 1'h1;
      cyc(2);
      chk(cact, 1'h1);
      cs <= lfi_pkg::lfi_cooler_sense_t'(3'h1 << i);
      cyc(1);
      cs <= '0;
      cyc(3);
      chk({st.cooler_fault_flag, eon}, 2'h2);
      cyc(5);
      chk(st.cooler_fault_flag, 1);
      csw <= 0;
      cyc(3);
      chk(cact, 0);
    end
  endtask
  initial begin
    t_start;
    t_lock;
    t_temp;
    t_oc;
    t_cool;
    close_out;
  end
  initial begin
    cyc(1500);
    failures++;
    close_out;
  end
endmodule
